//--- hw/ild_pkg.sv
/*
  Constants for the input level detector: register locations, config
  field positions, detector modes, leak codes and sizes.
  Assumes a single 100 MHz clock domain and a 16-bit address space.
*/
package ild_pkg;

  // ---------------------------------------------------------------
  // Register locations
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CONFIG     = 16'hF805;
  localparam logic [15:0] ADDR_START      = 16'hF806;
  localparam logic [15:0] ADDR_TEST_VALUE = 16'hF807;
  localparam logic [15:0] ADDR_TEST_STB   = 16'hF808;
  // Indirect read location of the detector output
  localparam logic [15:0] IRA_LEVEL       = 16'hF806;

  // ---------------------------------------------------------------
  // Config field positions
  // ---------------------------------------------------------------
  localparam int CFG_RECTIFY_BIT  = 21;
  localparam int CFG_FREE_RUN_BIT = 20;
  localparam int CFG_LEAK_HI      = 19;
  localparam int CFG_LEAK_LO      = 18;
  localparam int CFG_MODE_HI      = 17;
  localparam int CFG_MODE_LO      = 16;
  localparam int CFG_IVAL_HI      = 15;
  localparam int CFG_IVAL_LO      = 0;
  localparam int CFG_USED_W       = 22;

  // Qualification field positions (input control word)
  localparam int QUAL_DEMUX_HI    = 6;
  localparam int QUAL_DEMUX_LO    = 4;
  localparam int QUAL_INTERP_BIT  = 3;

  // Status word bit for interval done
  localparam int STATUS_DONE_BIT  = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
  localparam logic [15:0] TEST_VALUE_RESET = 16'h0000;
  localparam logic [15:0] IRA_RESET        = 16'h0000;

  // ---------------------------------------------------------------
  // Detector modes and leak codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LEAKY = 2'h0,
    MODE_PEAK  = 2'h1,
    MODE_INTEG = 2'h2,
    MODE_RSVD  = 2'h3
  } ild_mode_type;

  localparam logic [1:0] LEAK_ONE  = 2'h0;
  localparam logic [1:0] LEAK_M8   = 2'h1;
  localparam logic [1:0] LEAK_M12  = 2'h2;
  localparam logic [1:0] LEAK_M16  = 2'h3;
  localparam int SHIFT_M8  = 8;
  localparam int SHIFT_M12 = 12;
  localparam int SHIFT_M16 = 16;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int SAMPLE_W   = 16;
  localparam int DEMUX_MAX  = 7;
  localparam int FRAC_W     = 16;
  localparam int INT_W      = 34;
  localparam int READ_W     = 32;

endpackage : ild_pkg

//--- hw/ild_tap_delay.sv
/*
  Tapped delay line: delays a word by 0 to DEPTH clocks, tap chosen
  at run time. Tap 0 passes the input straight through.
  Assumes synchronous active-high reset.
*/
`timescale 1ns/1ns
module ild_tap_delay #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 7,
  parameter int SEL_W = 3
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data and tap select
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic [SEL_W-1:0] tap_i,
  output logic      [WIDTH-1:0] data_o
);

  // ---------------------------------------------------------------
  // Delay chain
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] stage_ff [1:DEPTH];
  wire  [WIDTH-1:0] tap_word [0:DEPTH];

  // Tap 0 is the undelayed word
  assign tap_word[0] = data_i;

  // One register per delay step
  for (genvar g = 1; g <= DEPTH; g++)
  begin : g_stage
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        stage_ff[g] <= '0;
      else
        stage_ff[g] <= tap_word[g-1];
    end
    assign tap_word[g] = stage_ff[g];
  end

  // Tap selection
  assign data_o = tap_word[tap_i];

endmodule : ild_tap_delay

//--- hw/ild_level_detector.sv
/*
  Input level detector with test input port. Takes formatted 16-bit
  samples, qualifies them by the sample strobe with a demultiplex
  delay, optionally rectifies them and measures them as a leaky
  integrator, peak detector or integrator over a sample interval.
  Assumes a synchronous write port carrying global write locations,
  and an indirect read location written before reading the data.
*/
`timescale 1ns/1ns
module ild_level_detector #(
  parameter int SAMPLE_W = ild_pkg::SAMPLE_W,
  parameter int IVAL_W   = 16
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Global write port
  input  wire logic                wr_en_i,
  input  wire logic [15:0]         wr_addr_i,
  input  wire logic [31:0]         wr_data_i,
  // Indirect read port
  input  wire logic                ira_wr_i,
  input  wire logic [15:0]         ira_addr_i,
  output logic      [31:0]         rd_data_o,
  // Sample input and qualification control
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic                input_sample_strobe_i,
  input  wire logic [6:0]          qual_ctrl_i,
  // Channel control bits for the test port
  input  wire logic                test_strobe_level_i,
  input  wire logic                test_strobe_by_write_i,
  input  wire logic                test_select_i,
  // Test port and status outputs
  output logic [SAMPLE_W-1:0]      test_value_o,
  output logic                     test_strobe_o,
  output logic [1:0]               status_o
);

  localparam int FRAC_W = ild_pkg::FRAC_W;
  localparam int INT_W  = ild_pkg::INT_W;
  localparam int ACC_W  = INT_W + FRAC_W;
  localparam int CNT_W  = IVAL_W + 1;

  // ---------------------------------------------------------------
  // Accumulator format
  // ---------------------------------------------------------------
  // Sample sits above FRAC_W fraction bits: small leak steps survive
  // INT_W integer bits: headroom for long integrations
  // Reads return low integer bits only: long sums wrap there
  // Counter one bit wider than the interval: holds interval plus one

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software-visible registers
  logic [31:0]         config_ff;
  logic [15:0]         test_value_ff;
  logic                test_strobe_ff;
  logic [15:0]         ira_ff;
  logic [31:0]         rd_data_ff;
  // Detector state
  logic signed [ACC_W-1:0] acc_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic                running_ff;
  logic                done_ff;

  // Next values, software side
  logic [31:0]         nxt_config;
  logic [15:0]         nxt_test_value;
  logic                nxt_test_strobe;
  logic [15:0]         nxt_ira;
  logic [31:0]         nxt_rd_data;
  // Next values, detector side
  logic signed [ACC_W-1:0] nxt_acc;
  logic [CNT_W-1:0]    nxt_cnt;
  logic                nxt_running;
  logic                nxt_done;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // One strobe per accepted write, high for one clock
  wire wr_config     = wr_en_i && (wr_addr_i == ild_pkg::ADDR_CONFIG);
  wire wr_start      = wr_en_i && (wr_addr_i == ild_pkg::ADDR_START);
  wire wr_test_value = wr_en_i && (wr_addr_i == ild_pkg::ADDR_TEST_VALUE);
  wire wr_test_stb   = wr_en_i && (wr_addr_i == ild_pkg::ADDR_TEST_STB);

  // ---------------------------------------------------------------
  // Config fields
  // ---------------------------------------------------------------
  // Slices of the config word
  wire              cfg_rectify  = config_ff[ild_pkg::CFG_RECTIFY_BIT];
  wire              cfg_free_run = config_ff[ild_pkg::CFG_FREE_RUN_BIT];
  wire [1:0]        cfg_leak     = config_ff[ild_pkg::CFG_LEAK_HI:ild_pkg::CFG_LEAK_LO];
  wire [1:0]        cfg_mode_raw = config_ff[ild_pkg::CFG_MODE_HI:ild_pkg::CFG_MODE_LO];
  wire [IVAL_W-1:0] cfg_ival     = config_ff[ild_pkg::CFG_IVAL_HI:ild_pkg::CFG_IVAL_LO];
  // Qualification control fields
  wire [2:0]        demux_tap    = qual_ctrl_i[ild_pkg::QUAL_DEMUX_HI:ild_pkg::QUAL_DEMUX_LO];
  wire              interp_mode  = qual_ctrl_i[ild_pkg::QUAL_INTERP_BIT];

  ild_pkg::ild_mode_type mode;
  assign mode = ild_pkg::ild_mode_type'(cfg_mode_raw);

  // ---------------------------------------------------------------
  // Test input port
  // ---------------------------------------------------------------
  // Strobe source: write pulse or channel level bit
  // strobe source select
  assign nxt_test_strobe = test_strobe_by_write_i ? wr_test_stb : test_strobe_level_i;
  // Test value kept until rewritten
  assign nxt_test_value  = wr_test_value ? wr_data_i[15:0] : test_value_ff;

  // Source mux: external samples or test value
  // test value as input
  wire [SAMPLE_W-1:0] src_sample = test_select_i ? test_value_ff : sample_i;
  wire                src_strobe = test_select_i ? test_strobe_ff : input_sample_strobe_i;

  // ---------------------------------------------------------------
  // Demultiplex delay
  // ---------------------------------------------------------------
  logic q_strobe;

  // Only the strobe is delayed: the word is taken live on the
  // capture clock, so tap n takes the nth word after the strobe
  // strobe-to-capture delay
  ild_tap_delay #(
    .WIDTH (1),
    .DEPTH (ild_pkg::DEMUX_MAX),
    .SEL_W (3)
  ) u_demux (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .data_i (src_strobe),
    .tap_i  (demux_tap),
    .data_o (q_strobe)
  );

  // Word present on the capture clock
  wire [SAMPLE_W-1:0] q_sample = src_sample;

  // ---------------------------------------------------------------
  // Qualification
  // ---------------------------------------------------------------
  // gated update on strobe
  wire                upd       = interp_mode ? 1'b1 : q_strobe;
  // Interpolated mode feeds zero while the strobe is high
  wire [SAMPLE_W-1:0] qual_samp = (interp_mode && q_strobe) ? '0 : q_sample;

  wire [SAMPLE_W-1:0] rect_samp = (cfg_rectify && qual_samp[SAMPLE_W-1]) ?
                                  ~qual_samp : qual_samp;

  // Sample scaled into accumulator format
  wire signed [ACC_W-1:0] x_acc = {{(INT_W-SAMPLE_W){rect_samp[SAMPLE_W-1]}},
                                   rect_samp, {FRAC_W{1'b0}}};

  // ---------------------------------------------------------------
  // Detector arithmetic
  // ---------------------------------------------------------------
  // Distance from the level to the new sample
  wire signed [ACC_W-1:0] diff = x_acc - acc_ff;

  // Arithmetic shift keeps the sign of a falling level
  // leak gain by shift
  logic signed [ACC_W-1:0] leak_step;
  always_comb
  begin
    case (cfg_leak)
      ild_pkg::LEAK_ONE: leak_step = diff;
      ild_pkg::LEAK_M8:  leak_step = diff >>> ild_pkg::SHIFT_M8;
      ild_pkg::LEAK_M12: leak_step = diff >>> ild_pkg::SHIFT_M12;
      ild_pkg::LEAK_M16: leak_step = diff >>> ild_pkg::SHIFT_M16;
      default:           leak_step = diff;
    endcase
  end

  // New detector value per mode
  logic signed [ACC_W-1:0] det_val;
  always_comb
  begin
    case (mode)
      // y = y + A*(x - y)
      ild_pkg::MODE_LEAKY: det_val = acc_ff + leak_step;
      ild_pkg::MODE_PEAK:  det_val = (x_acc > acc_ff) ? x_acc : acc_ff;
      ild_pkg::MODE_INTEG: det_val = acc_ff + x_acc;
      // Code 11 undefined: level holds
      default:             det_val = acc_ff;
    endcase
  end

  // ---------------------------------------------------------------
  // Interval control
  // ---------------------------------------------------------------
  // Counter loads interval plus one and counts down per update
  // The update that finds it at zero is the last and stops it
  // load count plus one, run count plus two
  wire [CNT_W-1:0] ival_load = CNT_W'({1'b0, cfg_ival}) + CNT_W'(1);
  wire             last_samp = running_ff && upd && (cnt_ff == '0);

  // Free run keeps accumulating once the counter has stopped
  // free run ignores counter
  wire             acc_en    = upd && (cfg_free_run || running_ff);

  // Accumulator, counter and run state
  always_comb
  begin
    nxt_acc     = acc_ff;
    nxt_cnt     = cnt_ff;
    nxt_running = running_ff;
    if (wr_start)
    begin
      nxt_acc     = '0;
      nxt_cnt     = ival_load;
      nxt_running = 1'b1;
    end
    else
    begin
      if (acc_en)
        nxt_acc = det_val;
      if (running_ff && upd)
      begin
        if (cnt_ff == '0)
          nxt_running = 1'b0;
        else
          nxt_cnt = cnt_ff - CNT_W'(1);
      end
    end
  end

  // A start in the cycle of the last update leaves done set
  // done flag, set wins over clear
  assign nxt_done = last_samp || (done_ff && !wr_start);

  // ---------------------------------------------------------------
  // Config and indirect read
  // ---------------------------------------------------------------
  // Unused high bits are kept at zero
  assign nxt_config = wr_config ?
                      {{(32-ild_pkg::CFG_USED_W){1'b0}}, wr_data_i[ild_pkg::CFG_USED_W-1:0]} :
                      config_ff;
  // Indirect read location, held until rewritten
  assign nxt_ira    = ira_wr_i ? ira_addr_i : ira_ff;

  // Integer part of the accumulator
  wire [31:0] level_word = acc_ff[FRAC_W +: ild_pkg::READ_W];

  // Indirect read selection
  wire rd_sel_level  = (ira_ff == ild_pkg::IRA_LEVEL);
  wire rd_sel_config = (ira_ff == ild_pkg::ADDR_CONFIG);
  wire rd_sel_test   = (ira_ff == ild_pkg::ADDR_TEST_VALUE);

  // Unknown locations read as zero
  // indirect read of level
  assign nxt_rd_data = rd_sel_level  ? level_word :
                       rd_sel_config ? config_ff :
                       rd_sel_test   ? {16'h0000, test_value_ff} :
                       32'h0000_0000;

  // ---------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------
  // Software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_ff     <= ild_pkg::CONFIG_RESET;
      test_value_ff <= ild_pkg::TEST_VALUE_RESET;
      ira_ff        <= ild_pkg::IRA_RESET;
    end
    else
    begin
      config_ff     <= nxt_config;
      test_value_ff <= nxt_test_value;
      ira_ff        <= nxt_ira;
    end
  end

  // Detector state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_ff     <= '0;
      cnt_ff     <= '0;
      running_ff <= 1'b0;
      done_ff    <= 1'b0;
    end
    else
    begin
      acc_ff     <= nxt_acc;
      cnt_ff     <= nxt_cnt;
      running_ff <= nxt_running;
      done_ff    <= nxt_done;
    end
  end

  // Output registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_strobe_ff <= 1'b0;
      rd_data_ff     <= 32'h0000_0000;
    end
    else
    begin
      test_strobe_ff <= nxt_test_strobe;
      rd_data_ff     <= nxt_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data_o     = rd_data_ff;
  assign test_value_o  = test_value_ff;
  assign test_strobe_o = test_strobe_ff;
  assign status_o      = {done_ff, 1'b0};   // Bit 1 = interval done

endmodule : ild_level_detector

//--- tb/ild_level_detector_chk.sv
/*
  Checker bound to the level detector: write side effects, test port
  and indirect read timing. Assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ns
module ild_level_detector_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Write and read ports
  input wire logic        wr_en_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        ira_wr_i,
  input wire logic [15:0] ira_addr_i,
  input wire logic [31:0] rd_data_o,
  // Test port and status
  input wire logic        test_strobe_level_i,
  input wire logic        test_strobe_by_write_i,
  input wire logic [15:0] test_value_o,
  input wire logic        test_strobe_o,
  input wire logic [1:0]  status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Decoded write strobes
  wire start_wr = wr_en_i && (wr_addr_i == ild_pkg::ADDR_START);
  wire tstb_wr  = wr_en_i && (wr_addr_i == ild_pkg::ADDR_TEST_STB);
  wire tval_wr  = wr_en_i && (wr_addr_i == ild_pkg::ADDR_TEST_VALUE);

  // Test strobe, test value, status and read relations
  property p_stb_wr; tstb_wr && test_strobe_by_write_i |=> test_strobe_o; endproperty
  a_stb_wr: assert property (p_stb_wr) else $error("test strobe missing");
  property p_stb_no; test_strobe_by_write_i && !tstb_wr |=> !test_strobe_o; endproperty
  a_stb_no: assert property (p_stb_no) else $error("test strobe unasked");
  property p_stb_lvl;
    !test_strobe_by_write_i |=> test_strobe_o == $past(test_strobe_level_i);
  endproperty
  a_stb_lvl: assert property (p_stb_lvl) else $error("level strobe wrong");
  property p_tval; tval_wr |=> test_value_o == $past(wr_data_i[15:0]); endproperty
  a_tval: assert property (p_tval) else $error("test value wrong");
  property p_clr; start_wr && status_o[1] |=> !status_o[1]; endproperty
  a_clr: assert property (p_clr) else $error("done not cleared");
  property p_sticky; status_o[1] && !start_wr |=> status_o[1]; endproperty
  a_sticky: assert property (p_sticky) else $error("done dropped");
  property p_rd_tv;
    ira_wr_i && ira_addr_i == ild_pkg::ADDR_TEST_VALUE ##1 !ira_wr_i
      |=> rd_data_o == {16'h0000, $past(test_value_o)};
  endproperty
  a_rd_tv: assert property (p_rd_tv) else $error("indirect read wrong");
  property p_rd_zero;
    ira_wr_i && ira_addr_i == 16'h0001 ##1 !ira_wr_i |=> rd_data_o == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unknown read not zero");

  // Main scenarios reached
  c_done: cover property ($rose(status_o[1]));
  c_tstb: cover property (tstb_wr ##1 test_strobe_o);
  c_start: cover property (start_wr);
endmodule : ild_level_detector_chk

bind ild_level_detector ild_level_detector_chk u_chk (.clk_i, .rst_i, .wr_en_i, .wr_addr_i,
  .wr_data_i, .ira_wr_i, .ira_addr_i, .rd_data_o, .test_strobe_level_i,
  .test_strobe_by_write_i, .test_value_o, .test_strobe_o, .status_o);

//--- tb/ild_sample_src.sv
/*
  Sample source model: sample strobe and formatted samples.
  Assumes its tasks are called at a falling clock edge.
*/
`timescale 1ns/1ns
module ild_sample_src (
  // Clock
  input  wire logic        clk_i,
  // Sample stream
  output logic      [15:0] sample_o,
  output logic             strobe_o
);
  // Quiet bus at start
  initial
  begin
    sample_o = 16'h0000;
    strobe_o = 1'b0;
  end

  task automatic send(input logic [15:0] v, input int d);
    int i;
    strobe_o = 1'b1;
    sample_o = (d == 0) ? v : ~v;
    for (i = 1; i <= d + 1; i++)
    begin
      @(negedge clk_i);
      strobe_o = 1'b0;
      // Stale word shown inverted
      sample_o = (i == d) ? v : ~v;
    end
    // Idle clock before the next strobe
    @(negedge clk_i);
  endtask : send

  // Constant word, no strobe
  task automatic hold(input logic [15:0] v);
    sample_o = v;
    strobe_o = 1'b0;
  endtask : hold

  task automatic pulse();
    strobe_o = 1'b1;
    @(negedge clk_i);
    strobe_o = 1'b0;
  endtask : pulse
endmodule : ild_sample_src

//--- tb/ild_level_detector_tb_top.sv
/*
  Testbench for the level detector: writes, indirect reads, samples.
  Assumes the sample source model and the bound checker.
*/
`timescale 1ns/1ns
module ild_level_detector_tb_top;
  logic        clk_i, rst_i, wr_en_i, ira_wr_i, input_sample_strobe_i, test_strobe_o;
  logic        test_strobe_level_i, test_strobe_by_write_i, test_select_i;
  logic [1:0]  status_o;
  logic [6:0]  qual_ctrl_i;
  logic [15:0] wr_addr_i, ira_addr_i, sample_i, test_value_o;
  logic [31:0] wr_data_i, rd_data_o;
  int          fail_count, checks;
  int          cyc = 0;

  // Design and sample source
  ild_level_detector dut (.clk_i, .rst_i, .wr_en_i, .wr_addr_i, .wr_data_i, .ira_wr_i,
    .ira_addr_i, .rd_data_o, .sample_i, .input_sample_strobe_i, .qual_ctrl_i,
    .test_strobe_level_i, .test_strobe_by_write_i, .test_select_i, .test_value_o,
    .test_strobe_o, .status_o);
  ild_sample_src src (.clk_i, .sample_o(sample_i), .strobe_o(input_sample_strobe_i));

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    wr_en_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    @(negedge clk_i);
    wr_en_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge clk_i);
    ira_wr_i = 1'b1;
    ira_addr_i = a;
    @(negedge clk_i);
    ira_wr_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(rd_data_o, exp);
  endtask : rd

  // Config write then start
  task automatic go(input logic [21:0] w);
    wr(ild_pkg::ADDR_CONFIG, {10'h000, w});
    wr(ild_pkg::ADDR_START, 32'h0000_0000);
  endtask : go

  // Two equal samples through the leaky update
  function automatic logic [31:0] leak2(input logic [15:0] x, input int sh);
    longint y;
    y = 0;
    repeat (2) y = y + (((longint'($signed(x)) <<< 16) - y) >>> sh);
    return y[47:16];
  endfunction : leak2

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Main sequence
  initial
  begin
    int d;
    int sh[4];
    sh = '{0, 8, 12, 16};
    rst_i = 1'b1;
    {wr_en_i, ira_wr_i, test_strobe_level_i, test_strobe_by_write_i, test_select_i} = 5'h00;
    {wr_addr_i, ira_addr_i, wr_data_i, qual_ctrl_i} = 71'h0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    rd(ild_pkg::ADDR_CONFIG, ild_pkg::CONFIG_RESET);
    check({16'h0000, test_value_o}, {16'h0000, ild_pkg::TEST_VALUE_RESET});
    rd(16'h0001, 32'h0000_0000);
    $display("reset test done");
    go(22'h22_0001);
    src.send(16'h0005, 0);
    src.send(16'hFFFD, 0);
    check({30'h0, status_o}, 32'h0000_0000);
    src.send(16'h0007, 0);
    check({30'h0, status_o}, 32'h0000_0002);
    src.send(16'h000A, 0);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_000E);
    wr(ild_pkg::ADDR_START, 32'hFFFF_FFFF);
    check({30'h0, status_o}, 32'h0000_0000);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_0000);
    go(22'h01_0001);
    src.send(16'hFFEC, 0);
    src.send(16'h0009, 0);
    src.send(16'h0003, 0);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_0009);
    $display("integrate and peak test done");
    for (d = 0; d < 4; d++)
    begin
      go({2'b00, d[1:0], 18'h00000});
      src.send(16'h4000, 0);
      src.send(16'h4000, 0);
      rd(ild_pkg::IRA_LEVEL, leak2(16'h4000, sh[d]));
    end
    go(22'h10_0000);
    for (d = 5; d < 8; d++)
      src.send(d[15:0], 0);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_0007);
    // free run dropped to hold the reading
    wr(ild_pkg::ADDR_CONFIG, 32'h0000_0000);
    src.send(16'h0009, 0);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_0007);
    $display("leaky and free run test done");
    for (d = 0; d < 8; d++)
    begin
      qual_ctrl_i = {d[2:0], 4'h0};
      go(22'h02_0000);
      src.send(d[15:0] + 16'h000A, d);
      src.send(d[15:0] + 16'h000A, d);
      rd(ild_pkg::IRA_LEVEL, 2 * (d + 10));
    end
    qual_ctrl_i = 7'h08;
    src.hold(16'h0003);
    go(22'h02_0003);
    src.pulse();
    repeat (6) @(negedge clk_i);
    check({30'h0, status_o}, 32'h0000_0002);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_000C);
    qual_ctrl_i = 7'h00;
    $display("demultiplex and interpolated test done");
    wr(ild_pkg::ADDR_TEST_VALUE, 32'h0000_0021);
    rd(ild_pkg::ADDR_TEST_VALUE, 32'h0000_0021);
    test_strobe_by_write_i = 1'b1;
    wr(ild_pkg::ADDR_TEST_STB, 32'h0000_0000);
    check({31'h0, test_strobe_o}, 32'h0000_0001);
    test_strobe_by_write_i = 1'b0;
    wr(ild_pkg::ADDR_TEST_STB, 32'h0000_0000);
    check({31'h0, test_strobe_o}, 32'h0000_0000);
    test_strobe_level_i = 1'b1;
    @(negedge clk_i);
    check({31'h0, test_strobe_o}, 32'h0000_0001);
    test_strobe_level_i = 1'b0;
    test_select_i = 1'b1;
    test_strobe_by_write_i = 1'b1;
    go(22'h02_0000);
    wr(ild_pkg::ADDR_TEST_STB, 32'h0000_0000);
    wr(ild_pkg::ADDR_TEST_STB, 32'h0000_0000);
    rd(ild_pkg::IRA_LEVEL, 32'h0000_0042);
    wr(16'hF80A, 32'h003F_FFFF);
    rd(ild_pkg::ADDR_CONFIG, 32'h0002_0000);
    $display("test port test done");
    complete_run();
  end
endmodule : ild_level_detector_tb_top
